// [design/ascf_framer.v]
`include "ascf_map.vh"
// Function
// - point-to-point mode: no start char or address, command from first char.
// - multidrop mode: frame starts only on the exclamation start character.
// - carriage return ends frame; pulses execute for a clean addressed frame, frame error for a faulty one.
// - line feeds are dropped and never touch parsing.
// - fields are printable ascii; numbers as text digits.
// - address is two ascii hex digits, 00 through FF accepted.
// - command mnemonic after address comma is one or two chars.
// - up to four comma separated arguments after the mnemonic.
// - after reset the own address is the default 11.
// - broadcast address executes but suppresses any reply.
// - broadcast memory write at location 118 sets new address 01 to FF.
// - after address change frames match the new address.
module ascf_framer #(
   parameter ARG_W = 16
) (
   input wire CLK,
   input wire SYS_RST,
   input wire MULTIDROP,
   input wire RX_VALID,
   input wire [7:0] RX_DATA,
   output reg EXEC,
   output reg REPLY_EN,
   output reg BCAST,
   output reg [15:0] CMD,
   output reg [2:0] ARG_CNT,
   output reg [ARG_W-1:0] FIRST_ARGUMENT,
   output reg [ARG_W-1:0] ARG2,
   output reg [ARG_W-1:0] ARG3,
   output reg [ARG_W-1:0] FOURTH_ARGUMENT,
   output reg FRAME_ERR,
   output reg [7:0] OWN_ADDR,
   output reg ADDR_CHANGED
);
   localparam S_IDLE = 6'b000001;
   localparam S_ADDR = 6'b000010;
   localparam S_ACOM = 6'b000100;
   localparam S_CMD = 6'b001000;
   localparam S_ARG = 6'b010000;
   localparam S_SKIP = 6'b100000;

   reg [5:0] state_reg;
   reg [5:0] state_next;
   reg [7:0] addr_reg;
   reg [1:0] adig_reg;
   reg [15:0] cmd_reg;
   reg [1:0] clen_reg;
   reg [2:0] argi_reg;
   reg bad_reg;
   reg [7:0] own_reg;

   wire is_lf = (RX_DATA == `ASCF_CH_LF);
   wire is_cr = (RX_DATA == `ASCF_CH_CR);
   wire is_comma = (RX_DATA == `ASCF_CH_COMMA);
   wire is_start = (RX_DATA == `ASCF_CH_START);
   wire is_print = (RX_DATA >= `ASCF_CH_PRINT_LO) && (RX_DATA <= `ASCF_CH_PRINT_HI);
   wire ch_in = RX_VALID && !is_lf;

   wire [3:0] anib;
   wire aok;
   ascf_hexdig u_adig (.ch(RX_DATA), .nib(anib), .ok(aok));

   // one accumulator per argument slot
   wire [15:0] acc_dec [0:3];
   wire [15:0] acc_hex [0:3];
   wire [7:0] acc_len [0:3];
   wire frame_open = (state_reg == S_IDLE) && ch_in;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_arg
         ascf_argacc u_acc (
            .clk(CLK),
            .clr(SYS_RST || frame_open),
            .en(ch_in && (state_reg == S_ARG) && (argi_reg == g) && !is_comma && !is_cr && is_print),
            .ch(RX_DATA),
            .dec_reg(acc_dec[g]),
            .hex_reg(acc_hex[g]),
            .len_reg(acc_len[g])
         );
      end
   endgenerate

   wire addr_bc = (addr_reg == `ASCF_ADDR_BCAST);
   wire addr_hit = addr_bc || (addr_reg == own_reg);
   wire memory_write_cmd = (cmd_reg == {`ASCF_CH_M, `ASCF_CH_W});
   // memory_write_cmd: first_argument is location, second the new address
   wire memory_write_addr = MULTIDROP && addr_bc && memory_write_cmd && (argi_reg >= 3'h1) &&
                            (acc_dec[0] == `ASCF_MEMORY_WRITE_LOC) && (acc_len[1] == `ASCF_ADDR_ARG_LEN) &&
                            (acc_hex[1][7:0] != `ASCF_ADDR_BCAST);

   always @* begin
      state_next = state_reg;
      case (state_reg)
         S_IDLE: begin
            if (ch_in) begin
               if (MULTIDROP)
                  state_next = is_start ? S_ADDR : S_IDLE;
               else if (is_cr)
                  state_next = S_IDLE;
               else
                  state_next = S_CMD;
            end
         end
         S_ADDR: if (ch_in) state_next = is_cr ? S_IDLE : (adig_reg == `ASCF_ADDR_LAST_DIG ? S_ACOM : S_ADDR);
         S_ACOM: if (ch_in) begin
            // a foreign frame with a clean address is skipped whole, so faults after its comma raise no error; an address fault still ends in an error
            if (is_cr)
               state_next = S_IDLE;
            else if (is_comma && !bad_reg && !addr_hit)
               state_next = S_SKIP;
            else
               state_next = S_CMD;
         end
         S_CMD: if (ch_in) state_next = is_cr ? S_IDLE : (is_comma ? S_ARG : S_CMD);
         S_ARG: if (ch_in) state_next = is_cr ? S_IDLE : S_ARG;
         S_SKIP: if (ch_in && is_cr) state_next = S_IDLE;
         default: state_next = S_IDLE;
      endcase
   end

   always @(posedge CLK) begin
      if (SYS_RST) begin
         state_reg <= S_IDLE;
         addr_reg <= 8'h00;
         adig_reg <= 2'h0;
         cmd_reg <= 16'h0000;
         clen_reg <= 2'h0;
         argi_reg <= 3'h0;
         bad_reg <= 1'b0;
         own_reg <= `ASCF_ADDR_DEFAULT;
         EXEC <= 1'b0;
         REPLY_EN <= 1'b0;
         BCAST <= 1'b0;
         CMD <= 16'h0000;
         ARG_CNT <= 3'h0;
         FIRST_ARGUMENT <= {ARG_W{1'b0}};
         ARG2 <= {ARG_W{1'b0}};
         ARG3 <= {ARG_W{1'b0}};
         FOURTH_ARGUMENT <= {ARG_W{1'b0}};
         FRAME_ERR <= 1'b0;
         OWN_ADDR <= `ASCF_ADDR_DEFAULT;
         ADDR_CHANGED <= 1'b0;
      end else begin
         state_reg <= state_next;
         EXEC <= 1'b0;
         FRAME_ERR <= 1'b0;
         ADDR_CHANGED <= 1'b0;
         OWN_ADDR <= own_reg;
         if (frame_open) begin
            adig_reg <= 2'h0;
            addr_reg <= 8'h00;
            clen_reg <= 2'h0;
            argi_reg <= 3'h0;
            bad_reg <= 1'b0;
            cmd_reg <= 16'h0000;
            if (!MULTIDROP && !is_cr) begin
               cmd_reg <= {8'h00, RX_DATA};
               clen_reg <= 2'h1;
               bad_reg <= !is_print;
            end
         end
         if (ch_in && !is_cr && !is_print && state_reg != S_IDLE)
            bad_reg <= 1'b1;
         case (state_reg)
            S_ADDR: if (ch_in && !is_cr) begin
               addr_reg <= {addr_reg[3:0], anib};
               adig_reg <= adig_reg + 2'h1;
               if (!aok)
                  bad_reg <= 1'b1;
            end
            S_ACOM: if (ch_in && !is_cr && !is_comma) bad_reg <= 1'b1;
            S_CMD: if (ch_in && !is_cr && !is_comma) begin
               if (clen_reg == `ASCF_MAX_CMD)
                  bad_reg <= 1'b1;
               else begin
                  cmd_reg <= {cmd_reg[7:0], RX_DATA};
                  clen_reg <= clen_reg + 2'h1;
               end
            end
            S_ARG: if (ch_in && !is_cr) begin
               // a trailing comma before CR opens no fifth argument; anything after it does
               if (argi_reg == `ASCF_MAX_ARGS)
                  bad_reg <= 1'b1;
               else if (is_comma)
                  argi_reg <= argi_reg + 3'h1;
            end
            default: ;
         endcase
         if (ch_in && is_cr && state_reg != S_IDLE && state_reg != S_SKIP) begin
            if (bad_reg || clen_reg == 2'h0 || (MULTIDROP && state_reg != S_CMD && state_reg != S_ARG))
               FRAME_ERR <= 1'b1;
            else if (!MULTIDROP || addr_hit) begin
               EXEC <= 1'b1;
               BCAST <= MULTIDROP && addr_bc;
               REPLY_EN <= !(MULTIDROP && addr_bc);
               CMD <= cmd_reg;
               if (state_reg != S_ARG)
                  ARG_CNT <= 3'h0;
               else if (argi_reg != `ASCF_MAX_ARGS && acc_len[argi_reg[1:0]] != 8'h00)
                  ARG_CNT <= argi_reg + 3'h1;
               else
                  ARG_CNT <= argi_reg;
               FIRST_ARGUMENT <= acc_dec[0][ARG_W-1:0];
               ARG2 <= acc_dec[1][ARG_W-1:0];
               ARG3 <= acc_dec[2][ARG_W-1:0];
               FOURTH_ARGUMENT <= acc_dec[3][ARG_W-1:0];
               if (memory_write_addr) begin
                  own_reg <= acc_hex[1][7:0];
                  ADDR_CHANGED <= 1'b1;
               end
            end
         end
      end
   end
endmodule

// [design/ascf_map.vh]
`ifndef ASCF_MAP_VH
`define ASCF_MAP_VH
// ascii codes
`define ASCF_CH_START 8'h21
`define ASCF_CH_COMMA 8'h2C
`define ASCF_CH_CR 8'h0D
`define ASCF_CH_LF 8'h0A
`define ASCF_CH_COLON 8'h3A
`define ASCF_CH_PRINT_LO 8'h20
`define ASCF_CH_PRINT_HI 8'h7E
`define ASCF_CH_D0 8'h30
`define ASCF_CH_D9 8'h39
`define ASCF_CH_UA 8'h41
`define ASCF_CH_UF 8'h46
`define ASCF_CH_LA 8'h61
`define ASCF_CH_LF_HEX 8'h66
`define ASCF_CH_M 8'h4D
`define ASCF_CH_W 8'h57
// addressing
`define ASCF_ADDR_DEFAULT 8'h11
`define ASCF_ADDR_BCAST 8'h00
// location 118 decimal, compared against the decimal value of the first argument
`define ASCF_MEMORY_WRITE_LOC 16'h0076
`define ASCF_ADDR_LAST_DIG 2'h1
`define ASCF_ADDR_ARG_LEN 8'h02
// limits
`define ASCF_MAX_ARGS 3'h4
`define ASCF_MAX_CMD 2'h2
`endif

// [design/ascf_hexdig.v]
`include "ascf_map.vh"
// one ascii hex digit to nibble, with validity
module ascf_hexdig (
   input wire [7:0] ch,
   output reg [3:0] nib,
   output reg ok
);
   always @* begin
      nib = 4'h0;
      ok = 1'b0;
      if (ch >= `ASCF_CH_D0 && ch <= `ASCF_CH_D9) begin
         nib = ch[3:0];
         ok = 1'b1;
      end else if ((ch >= `ASCF_CH_UA && ch <= `ASCF_CH_UF) ||
                   (ch >= `ASCF_CH_LA && ch <= `ASCF_CH_LF_HEX)) begin
         nib = ch[3:0] + 4'h9;
         ok = 1'b1;
      end
   end
endmodule

// [design/ascf_argacc.v]
`include "ascf_map.vh"
// accumulates one argument field as decimal value and as hex value
module ascf_argacc (
   input wire clk,
   input wire clr,
   input wire en,
   input wire [7:0] ch,
   output reg [15:0] dec_reg,
   output reg [15:0] hex_reg,
   output reg [7:0] len_reg
);
   wire [3:0] nib;
   wire ok;
   ascf_hexdig u_dig (.ch(ch), .nib(nib), .ok(ok));
   always @(posedge clk) begin
      if (clr) begin
         dec_reg <= 16'h0000;
         hex_reg <= 16'h0000;
         len_reg <= 8'h00;
      end else if (en) begin
         if (ch >= `ASCF_CH_D0 && ch <= `ASCF_CH_D9)
            dec_reg <= (dec_reg * 16'h000A) + {12'h000, ch[3:0]};
         if (ok)
            hex_reg <= {hex_reg[11:0], nib};
         if (len_reg != 8'hFF)
            len_reg <= len_reg + 8'h01;
      end
   end
endmodule

// [dv/ascf_host.sv]
module ascf_host (
   input wire logic clk,
   output logic valid,
   output logic [7:0] data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      valid = 1'h0;
      data = 8'h00;
   end
   // printable text ended by carriage return, start char and address only on multidrop
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         @(posedge clk);
         valid <= 1'h1;
         data <= s[i];
      end
      @(posedge clk);
      valid <= 1'h0;
      data <= ~data; // released line must not repeat the last char
   endtask
endmodule

// [dv/ascf_props.sv]
module ascf_props #(
   parameter ARG_W = 16
) (
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic MULTIDROP,
   input wire logic RX_VALID,
   input wire logic [7:0] RX_DATA,
   input wire logic EXEC,
   input wire logic REPLY_EN,
   input wire logic BCAST,
   input wire logic [2:0] ARG_CNT,
   input wire logic [7:0] OWN_ADDR,
   input wire logic ADDR_CHANGED,
   input wire logic FRAME_ERR
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   wire cr_in = RX_VALID && RX_DATA == 8'h0D;
   a_exec_on_cr: assert property (EXEC |-> $past(cr_in) || $past(cr_in, 2))
      else $error("exec without carriage return");
   a_exec_pulse: assert property (EXEC |=> !EXEC) else $error("exec held");
   a_exec_err_excl: assert property (!(EXEC && FRAME_ERR)) else $error("exec and error together");
   a_err_on_cr: assert property (FRAME_ERR |-> $past(cr_in)) else $error("error without carriage return");
   a_bcast_quiet: assert property (EXEC && BCAST |-> !REPLY_EN) else $error("reply on broadcast");
   a_addr_reply: assert property (EXEC && !BCAST |-> REPLY_EN) else $error("no reply enable");
   a_ptp_direct: assert property (EXEC && !MULTIDROP |-> !BCAST) else $error("broadcast on p2p");
   a_args_max: assert property (EXEC |-> ARG_CNT <= 3'h4) else $error("too many args");
   a_change_bcast: assert property (ADDR_CHANGED |-> EXEC && BCAST && MULTIDROP)
      else $error("address change without broadcast");
   a_addr_hold: assert property ($changed(OWN_ADDR) |-> $past(ADDR_CHANGED) || $past(ADDR_CHANGED, 2))
      else $error("own address moved");
   a_reset_addr: assert property (disable iff (1'h0) SYS_RST ##1 SYS_RST |=> OWN_ADDR == 8'h11)
      else $error("reset address wrong");
endmodule
bind ascf_framer ascf_props #(.ARG_W(ARG_W)) i_props (.CLK(CLK), .SYS_RST(SYS_RST), .MULTIDROP(MULTIDROP),
   .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .EXEC(EXEC), .REPLY_EN(REPLY_EN), .BCAST(BCAST),
   .ARG_CNT(ARG_CNT), .OWN_ADDR(OWN_ADDR), .ADDR_CHANGED(ADDR_CHANGED), .FRAME_ERR(FRAME_ERR));

// [dv/tb.sv]
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {string s; logic md; logic [1:0] kind; logic [15:0] cmd; logic [2:0] cnt;
      logic [15:0] a1; logic [1:0] br;} ascf_row_t;
   logic CLK = 1'h0;
   logic SYS_RST = 1'h1;
   logic MULTIDROP = 1'h1;
   wire RX_VALID, EXEC, REPLY_EN, BCAST, FRAME_ERR, ADDR_CHANGED;
   wire [7:0] RX_DATA, OWN_ADDR;
   wire [15:0] CMD, FIRST_ARGUMENT, ARG2, ARG3, FOURTH_ARGUMENT;
   wire [2:0] ARG_CNT;
   int bad_count = 0;
   int comparisons = 0;
   ascf_row_t rows [12] = '{
      '{"!11,ABC\015", 1'h1, 2'h2, 16'h0, 3'h0, 16'h0, 2'h0},
      '{"!1G,F\015", 1'h1, 2'h2, 16'h0, 3'h0, 16'h0, 2'h0},
      '{"F\001\015", 1'h0, 2'h2, 16'h0, 3'h0, 16'h0, 2'h0},
      '{"!11,F\015", 1'h1, 2'h1, 16'h0046, 3'h0, 16'h0, 2'h1},
      '{"F\015", 1'h0, 2'h1, 16'h0046, 3'h0, 16'h0, 2'h1},
      '{"!11,SP,100\015", 1'h1, 2'h1, 16'h5350, 3'h1, 16'h0064, 2'h1},
      '{"!12,F\015", 1'h1, 2'h0, 16'h0, 3'h0, 16'h0, 2'h0},
      '{"!00,G\015", 1'h1, 2'h1, 16'h0047, 3'h0, 16'h0, 2'h2},
      '{"!11,FA,1,2,3,4\015", 1'h1, 2'h1, 16'h4641, 3'h4, 16'h0001, 2'h1},
      '{"!11,F,1,2,3,4,5\015", 1'h1, 2'h2, 16'h0, 3'h0, 16'h0, 2'h0},
      '{"G\012\015", 1'h0, 2'h1, 16'h0047, 3'h0, 16'h0, 2'h1},
      '{"xy!11,G\015", 1'h1, 2'h1, 16'h0047, 3'h0, 16'h0, 2'h1}};
   always #12.5 CLK = ~CLK;
   ascf_host i_host (.clk(CLK), .valid(RX_VALID), .data(RX_DATA));
   ascf_framer i_dut (.CLK(CLK), .SYS_RST(SYS_RST), .MULTIDROP(MULTIDROP), .RX_VALID(RX_VALID),
      .RX_DATA(RX_DATA), .EXEC(EXEC), .REPLY_EN(REPLY_EN), .BCAST(BCAST), .CMD(CMD), .ARG_CNT(ARG_CNT),
      .FIRST_ARGUMENT(FIRST_ARGUMENT), .ARG2(ARG2), .ARG3(ARG3), .FOURTH_ARGUMENT(FOURTH_ARGUMENT), .FRAME_ERR(FRAME_ERR), .OWN_ADDR(OWN_ADDR),
      .ADDR_CHANGED(ADDR_CHANGED));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic run_row(input ascf_row_t r);
      @(posedge CLK);
      MULTIDROP <= r.md;
      i_host.send(r.s);
      // send returns on the edge that launches the one-cycle pulse
      #1;
      for (int i = 0; i < 4; i++) begin
         if (EXEC === 1'h1 || FRAME_ERR === 1'h1) break;
         @(posedge CLK);
         #1;
      end
      chk({14'h0, FRAME_ERR, EXEC}, {14'h0, r.kind});
      if (r.kind == 2'h1) begin
         chk(CMD, r.cmd);
         chk({13'h0, ARG_CNT}, {13'h0, r.cnt});
         chk(FIRST_ARGUMENT, r.a1);
         chk({14'h0, BCAST, REPLY_EN}, {14'h0, r.br});
      end
   endtask
   task automatic readdr(input string s, input logic [7:0] a, input logic ch);
      run_row(ascf_row_t'{s, 1'h1, 2'h1, 16'h4D57, 3'h2, 16'h0076, 2'h2});
      chk({15'h0, ADDR_CHANGED}, {15'h0, ch});
      repeat (2) @(posedge CLK);
      #1;
      chk({8'h0, OWN_ADDR}, {8'h0, a});
   endtask
   initial begin
      repeat (6) @(posedge CLK);
      SYS_RST <= 1'h0;
      @(posedge CLK);
      #1;
      chk({8'h0, OWN_ADDR}, 16'h0011);
      foreach (rows[i]) run_row(rows[i]);
      run_row(ascf_row_t'{"!11,FA,7,20,300,4000,\015", 1'h1, 2'h1, 16'h4641, 3'h4, 16'h0007, 2'h1});
      chk(ARG2, 16'h0014);
      chk(ARG3, 16'h012C);
      chk(FOURTH_ARGUMENT, 16'h0FA0);
      readdr("!00,MW,118,00,\015", 8'h11, 1'h0);
      readdr("!00,MW,118,2A,\015", 8'h2A, 1'h1);
      run_row(ascf_row_t'{"!11,F\015", 1'h1, 2'h0, 16'h0, 3'h0, 16'h0, 2'h0});
      run_row(ascf_row_t'{"!2a,F\015", 1'h1, 2'h1, 16'h0046, 3'h0, 16'h0, 2'h1});
      readdr("!00,MW,118,FF,\015", 8'hFF, 1'h1);
      run_row(ascf_row_t'{"!FF,G\015", 1'h1, 2'h1, 16'h0047, 3'h0, 16'h0, 2'h1});
      @(posedge CLK);
      SYS_RST <= 1'h1;
      repeat (3) @(posedge CLK);
      SYS_RST <= 1'h0;
      repeat (2) @(posedge CLK);
      #1;
      chk({8'h0, OWN_ADDR}, 16'h0011);
      report_and_stop();
   end
   // roughly seventeen times the expected run
   initial begin
      #100000;
      bad_count++;
      report_and_stop();
   end
endmodule
